/* include/pefpc_pkg.sv */
// Overview of operation
// - an alternate function on a control pin overrides that pin's direction bit
// - normal single-chip reset: every control pin is general-purpose I/O
// - special single-chip reset: bus clock output on, others general-purpose I/O
// - normal expanded reset: only bus clock enabled; software enables the rest
// - special expanded reset: pipe status, bus clock, read/write, low strobe enabled
// - peripheral mode: function select register not accessible, writes ignored
// - select bits write once in normal modes; special ignores first write
// - data enable disable 1 makes pin 7 I/O, 0 makes it data enable
// - clock test routes to pin 6 only special expanded; pipe output overrides
// - pipe output enable puts queue status on pins 6,5; not single-chip
// - clock output disable stays 0 in expanded; once normal, free special single-chip
// - single-chip: pin 4 bus clock if not disabled and visibility or no stretch
// - strobe enable drives low strobe on pin 3; not single-chip or narrow normal
// - read/write enable drives pin 2 with read/write; not in single-chip
// - control pullup enable covers pins 7,3,2,1,0; pin 1 always; 6,5,4 never
// - pullups act only on input pins; pullup register absent in peripheral mode
// - bus port pullups inactive while that port carries address/data
// - reduced drive bits cover all output pins of a port regardless of function
// - drive register write once normal, first write ignored special, absent peripheral
// - one 16-bit write sets clock disable, visibility and stretch together
// - direction 1 output, 0 input; pins 1 and 0 never outputs
package pefpc_pkg;

  typedef enum logic [2:0] {
    MODE_NORM_SINGLE,
    MODE_SPEC_SINGLE,
    MODE_NORM_EXP_NARROW,
    MODE_NORM_EXP_WIDE,
    MODE_SPEC_EXP_NARROW,
    MODE_SPEC_EXP_WIDE,
    MODE_PERIPHERAL
  } pefpc_mode_e;

  // alternate-function values presented to the control port
  typedef struct packed {
    logic       data_en;
    logic [1:0] pipe_status;
    logic       clk_test;
    logic       bus_clk;
    logic       low_byte_strobe;
    logic       read_write;
  } pefpc_func_s;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FSEL   = 8'h0A;
  localparam logic [7:0] IDX_MODE   = 8'h0B;
  localparam logic [7:0] IDX_PULLUP = 8'h0C;
  localparam logic [7:0] IDX_DRIVE  = 8'h0D;

  // function select fields
  localparam int BIT_DATA_ENABLE_DISABLE = 7;
  localparam int BIT_CLOCK_TEST_OUTPUT_EN = 6;
  localparam int BIT_PIPE_OUTPUT_EN = 5;
  localparam int BIT_CLOCK_OUTPUT_DISABLE = 4;
  localparam int BIT_STROBE_ENABLE = 3;
  localparam int BIT_READ_WRITE_ENABLE = 2;
  localparam logic [7:0] FSEL_IMPL_MASK = 8'hFC;

  // mode register fields
  localparam int BIT_INTERNAL_VISIBILITY = 3;
  localparam int BIT_CLOCK_STRETCH = 0;

  // pullup and drive fields
  localparam int BIT_CTRL_PORT = 4;
  localparam int BIT_LOW_BUS_PORT = 1;
  localparam int BIT_HIGH_BUS_PORT = 0;

  // function select value after reset, per mode
  localparam logic [7:0] FSEL_RST_NORM_SINGLE = 8'h90;
  localparam logic [7:0] FSEL_RST_SPEC_SINGLE = 8'h80;
  localparam logic [7:0] FSEL_RST_NORM_EXP    = 8'h80;
  localparam logic [7:0] FSEL_RST_SPEC_EXP    = 8'hAC;
  localparam logic [7:0] FSEL_RST_PERIPHERAL  = 8'h00;
  localparam logic [7:0] MODE_RST             = 8'h00;
  localparam logic [7:0] PULLUP_RST           = 8'h10;
  localparam logic [7:0] DRIVE_RST            = 8'h00;

endpackage

/* hdl/pefpc_write_once.sv */
`timescale 1ns/1ps
module pefpc_write_once (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_rst_n,    // sync reset, active low
  input  wire logic i_wr,       // write attempt this cycle
  input  wire logic i_special,  // special mode in force
  output logic      o_accept    // attempt may update the register
);
  logic lock_ff;

  // normal: only first write lands; special: first write is swallowed
  assign o_accept = i_wr & (i_special ? lock_ff : ~lock_ff);

  // ---------------------------------------------------------------
  // lock flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      lock_ff <= 1'b0;
    end else if (i_wr) begin
      lock_ff <= 1'b1;
    end
  end
endmodule

/* hdl/pefpc_top.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module pefpc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              i_clk_sys,       // 50 MHz system clock
  input  wire logic              i_rst_n,         // sync reset, active low
  input  wire logic [2:0]        i_op_mode,       // operating mode, pefpc_mode_e
  // apb slave
  input  wire logic              i_psel,          // apb select
  input  wire logic              i_penable,       // apb enable
  input  wire logic              i_pwrite,        // apb direction
  input  wire logic [ADDR_W-1:0] i_paddr,         // apb byte address
  input  wire logic [31:0]       i_pwdata,        // apb write data
  input  wire logic [3:0]        i_pstrb,         // apb byte strobes
  output logic      [31:0]       o_prdata,        // apb read data
  output logic                   o_pready,        // apb ready
  output logic                   o_pslverr,       // apb error
  // control port core side
  input  wire pefpc_pkg::pefpc_func_s i_func,     // alternate function values
  input  wire logic [7:0]        i_ctrl_port_direction, // gpio direction
  input  wire logic [7:0]        i_ctrl_port_data,      // gpio output data
  input  wire logic [7:0]        i_high_bus_dir,  // high bus port direction
  input  wire logic [7:0]        i_low_bus_dir,   // low bus port direction
  // control port pads
  input  wire logic [7:0]        i_pe_in,         // pad input levels
  output logic      [7:0]        o_pe_out,        // pad output levels
  output logic      [7:0]        o_pe_oe,         // pad output enables
  output logic      [7:0]        o_pe_pullup,     // pad pullup enables
  output logic      [7:0]        o_ctrl_port_in,  // pad levels to core
  output logic      [7:0]        o_high_bus_pullup, // high bus port pullups
  output logic      [7:0]        o_low_bus_pullup,  // low bus port pullups
  output logic                   o_ctrl_port_low_drive, // reduced drive
  output logic                   o_high_bus_port_low_drive, // reduced drive
  output logic                   o_low_bus_port_low_drive   // reduced drive
);

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  pefpc_pkg::pefpc_mode_e mode;
  logic                   single_chip;
  logic                   special;
  logic                   peripheral;
  logic                   expanded;
  logic                   norm_narrow;

  assign mode        = pefpc_pkg::pefpc_mode_e'(i_op_mode);
  assign single_chip = (mode == pefpc_pkg::MODE_NORM_SINGLE) |
                       (mode == pefpc_pkg::MODE_SPEC_SINGLE);
  assign special     = (mode == pefpc_pkg::MODE_SPEC_SINGLE) |
                       (mode == pefpc_pkg::MODE_SPEC_EXP_NARROW) |
                       (mode == pefpc_pkg::MODE_SPEC_EXP_WIDE);
  assign peripheral  = (mode == pefpc_pkg::MODE_PERIPHERAL);
  assign expanded    = ~single_chip & ~peripheral;
  assign norm_narrow = (mode == pefpc_pkg::MODE_NORM_EXP_NARROW);

  function automatic logic [7:0] fsel_reset(input pefpc_pkg::pefpc_mode_e m);
    case (m)
      pefpc_pkg::MODE_NORM_SINGLE:     fsel_reset = pefpc_pkg::FSEL_RST_NORM_SINGLE;
      pefpc_pkg::MODE_SPEC_SINGLE:     fsel_reset = pefpc_pkg::FSEL_RST_SPEC_SINGLE;
      pefpc_pkg::MODE_NORM_EXP_NARROW: fsel_reset = pefpc_pkg::FSEL_RST_NORM_EXP;
      pefpc_pkg::MODE_NORM_EXP_WIDE:   fsel_reset = pefpc_pkg::FSEL_RST_NORM_EXP;
      pefpc_pkg::MODE_SPEC_EXP_NARROW: fsel_reset = pefpc_pkg::FSEL_RST_SPEC_EXP;
      pefpc_pkg::MODE_SPEC_EXP_WIDE:   fsel_reset = pefpc_pkg::FSEL_RST_SPEC_EXP;
      default:                         fsel_reset = pefpc_pkg::FSEL_RST_PERIPHERAL;
    endcase
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic hit_fsel;
  logic hit_mode;
  logic hit_pullup;
  logic hit_drive;
  logic mapped;
  logic setup_phase;
  logic wr_commit;

  // peripheral mode removes all four registers from the map
  assign hit_fsel    = addr_is(i_paddr, pefpc_pkg::IDX_FSEL) & ~peripheral;
  assign hit_mode    = addr_is(i_paddr, pefpc_pkg::IDX_MODE) & ~peripheral;
  assign hit_pullup  = addr_is(i_paddr, pefpc_pkg::IDX_PULLUP) & ~peripheral;
  assign hit_drive   = addr_is(i_paddr, pefpc_pkg::IDX_DRIVE) & ~peripheral;
  assign mapped      = hit_fsel | hit_mode | hit_pullup | hit_drive;
  assign setup_phase = i_psel & ~i_penable;
  assign wr_commit   = i_psel & i_penable & o_pready & i_pwrite & mapped;

  logic wr_fsel_lo;
  logic wr_fsel_hi;
  logic wr_mode;
  logic wr_pullup;
  logic wr_drive;

  // upper byte of the function select word aliases the mode byte
  assign wr_fsel_lo = wr_commit & hit_fsel & i_pstrb[0];
  assign wr_fsel_hi = wr_commit & hit_fsel & i_pstrb[1];
  assign wr_mode    = (wr_commit & hit_mode & i_pstrb[0]) | wr_fsel_hi;
  assign wr_pullup  = wr_commit & hit_pullup & i_pstrb[0];
  assign wr_drive   = wr_commit & hit_drive & i_pstrb[0];

  logic [7:0] mode_wdata;
  assign mode_wdata = hit_fsel ? i_pwdata[15:8] : i_pwdata[7:0];

  // ---------------------------------------------------------------
  // write-once gates
  // ---------------------------------------------------------------
  logic fsel_accept;
  logic drive_accept;

  pefpc_write_once u_fsel_once (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_wr      (wr_fsel_lo),
    .i_special (special),
    .o_accept  (fsel_accept)
  );

  pefpc_write_once u_drive_once (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_wr      (wr_drive),
    .i_special (special),
    .o_accept  (drive_accept)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] fsel_ff;
  logic [7:0] mode_reg_ff;
  logic [7:0] pullup_ff;
  logic [7:0] drive_ff;
  logic [7:0] nxt_fsel;
  logic       clk_dis_accept;

  // clock disable: held 0 expanded, once normal single, free special single
  always_comb begin
    if (expanded) begin
      clk_dis_accept = 1'b0;
    end else if (mode == pefpc_pkg::MODE_SPEC_SINGLE) begin
      clk_dis_accept = wr_fsel_lo;
    end else begin
      clk_dis_accept = fsel_accept;
    end
  end

  always_comb begin
    nxt_fsel = fsel_ff;
    if (fsel_accept) begin
      nxt_fsel = i_pwdata[7:0] & pefpc_pkg::FSEL_IMPL_MASK;
    end
    nxt_fsel[pefpc_pkg::BIT_CLOCK_OUTPUT_DISABLE] = expanded ? 1'b0 :
      (clk_dis_accept ? i_pwdata[pefpc_pkg::BIT_CLOCK_OUTPUT_DISABLE] :
       fsel_ff[pefpc_pkg::BIT_CLOCK_OUTPUT_DISABLE]);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      fsel_ff <= fsel_reset(mode);
    end else begin
      fsel_ff <= nxt_fsel;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_reg_ff <= pefpc_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_reg_ff <= mode_wdata & 8'h09;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pullup_ff <= pefpc_pkg::PULLUP_RST;
    end else if (wr_pullup) begin
      pullup_ff <= i_pwdata[7:0] & 8'h13;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      drive_ff <= pefpc_pkg::DRIVE_RST;
    end else if (drive_accept) begin
      drive_ff <= i_pwdata[7:0] & 8'h13;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: data ready at access phase, no wait states
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_fsel) begin
      rd_mux = {16'h0000, mode_reg_ff, fsel_ff};
    end else if (hit_mode) begin
      rd_mux = {24'h000000, mode_reg_ff};
    end else if (hit_pullup) begin
      rd_mux = {24'h000000, pullup_ff};
    end else if (hit_drive) begin
      rd_mux = {24'h000000, drive_ff};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      o_pslverr <= ~mapped;
    end else begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin function selection
  // ---------------------------------------------------------------
  logic sel_data_en;
  logic sel_pipe;
  logic sel_clk_test;
  logic sel_bus_clk;
  logic sel_strobe;
  logic sel_rw;
  logic clk_off;

  assign clk_off      = fsel_ff[pefpc_pkg::BIT_CLOCK_OUTPUT_DISABLE];
  assign sel_data_en  = ~fsel_ff[pefpc_pkg::BIT_DATA_ENABLE_DISABLE];
  assign sel_pipe     = fsel_ff[pefpc_pkg::BIT_PIPE_OUTPUT_EN] & ~single_chip;
  // test clock is only honoured in special expanded, and pipe wins
  assign sel_clk_test = fsel_ff[pefpc_pkg::BIT_CLOCK_TEST_OUTPUT_EN] & special & expanded &
                        ~sel_pipe;
  assign sel_bus_clk  = single_chip ?
                        (~clk_off & (mode_reg_ff[pefpc_pkg::BIT_INTERNAL_VISIBILITY] |
                                     ~mode_reg_ff[pefpc_pkg::BIT_CLOCK_STRETCH])) :
                        (~clk_off & expanded);
  assign sel_strobe   = fsel_ff[pefpc_pkg::BIT_STROBE_ENABLE] & expanded & ~norm_narrow;
  assign sel_rw       = fsel_ff[pefpc_pkg::BIT_READ_WRITE_ENABLE] & expanded;

  logic [7:0] alt_sel;
  logic [7:0] alt_val;
  logic [7:0] nxt_out;
  logic [7:0] nxt_oe;
  logic [7:0] is_input;

  always_comb begin
    alt_sel    = 8'h00;
    alt_val    = 8'h00;
    alt_sel[7] = sel_data_en;
    alt_val[7] = i_func.data_en;
    alt_sel[6] = sel_pipe | sel_clk_test;
    alt_val[6] = sel_pipe ? i_func.pipe_status[1] : i_func.clk_test;
    alt_sel[5] = sel_pipe;
    alt_val[5] = i_func.pipe_status[0];
    alt_sel[4] = sel_bus_clk;
    alt_val[4] = i_func.bus_clk;
    alt_sel[3] = sel_strobe;
    alt_val[3] = i_func.low_byte_strobe;
    alt_sel[2] = sel_rw;
    alt_val[2] = i_func.read_write;
  end

  always_comb begin
    // alternate function overrides direction; interrupt pins stay inputs
    nxt_oe      = alt_sel | (i_ctrl_port_direction & ~alt_sel);
    nxt_oe[1:0] = 2'h0;
    nxt_out     = (alt_sel & alt_val) | (~alt_sel & i_ctrl_port_data);
    nxt_out[1:0] = 2'h0;
    is_input    = ~nxt_oe;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pe_out       <= 8'h00;
      o_pe_oe        <= 8'h00;
      o_ctrl_port_in <= 8'h00;
    end else begin
      o_pe_out       <= nxt_out;
      o_pe_oe        <= nxt_oe;
      o_ctrl_port_in <= i_pe_in;
    end
  end

  // ---------------------------------------------------------------
  // pullups and drive
  // ---------------------------------------------------------------
  logic [7:0] nxt_pe_pull;
  logic       ctrl_pull_en;
  logic       bus_ports_busy;

  assign ctrl_pull_en   = pullup_ff[pefpc_pkg::BIT_CTRL_PORT];
  assign bus_ports_busy = ~single_chip;  // address/data bus in expanded and peripheral

  always_comb begin
    nxt_pe_pull    = {8{ctrl_pull_en}} & 8'h8D & is_input;
    nxt_pe_pull[1] = 1'b1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pe_pullup       <= 8'h00;
      o_high_bus_pullup <= 8'h00;
      o_low_bus_pullup  <= 8'h00;
    end else begin
      o_pe_pullup       <= nxt_pe_pull;
      o_high_bus_pullup <= {8{pullup_ff[pefpc_pkg::BIT_HIGH_BUS_PORT] & ~bus_ports_busy}} &
                           ~i_high_bus_dir;
      o_low_bus_pullup  <= {8{pullup_ff[pefpc_pkg::BIT_LOW_BUS_PORT] & ~bus_ports_busy}} &
                           ~i_low_bus_dir;
    end
  end

  // reduced drive is per port and blind to pin function
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ctrl_port_low_drive     <= 1'b0;
      o_high_bus_port_low_drive <= 1'b0;
      o_low_bus_port_low_drive  <= 1'b0;
    end else begin
      o_ctrl_port_low_drive     <= drive_ff[pefpc_pkg::BIT_CTRL_PORT];
      o_high_bus_port_low_drive <= drive_ff[pefpc_pkg::BIT_HIGH_BUS_PORT];
      o_low_bus_port_low_drive  <= drive_ff[pefpc_pkg::BIT_LOW_BUS_PORT];
    end
  end

  // strobe pin tagging by an external debugger arrives on i_pe_in[3]
  // and is passed to the core unchanged

endmodule

/* testbench/pefpc_pad_model.sv */
`timescale 1ns/1ps
module pefpc_pad_model (
  input  wire logic       i_clk_sys, // system clock
  input  wire logic [7:0] i_out,     // device pad data
  input  wire logic [7:0] i_oe,      // device drives pad
  input  wire logic [7:0] i_pull,    // pullup switched on
  input  wire logic       i_tag,     // debugger tag request
  output logic      [7:0] o_level    // resolved pad level
);
  // ---
  // pad resolution
  // ---
  logic [7:0] float_ff = 8'hA5;
  logic       tag_ff   = 1'h0;
  // floating pads wander so a stale level never passes
  always_ff @(posedge i_clk_sys) begin
    float_ff <= ~float_ff;
  end
  // debugger samples its tag on the falling system clock edge
  always_ff @(negedge i_clk_sys) begin
    tag_ff <= i_tag;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_level[i] = i_oe[i] ? i_out[i] : (i_pull[i] ? 1'h1 : float_ff[i]);
    end
    if (tag_ff && !i_oe[3]) begin
      o_level[3] = 1'h0;
    end
  end
endmodule

/* testbench/pefpc_asserts.sv */
`timescale 1ns/1ps
module pefpc_asserts (
  input wire logic                   i_clk_sys,             // clock
  input wire logic                   i_rst_n,               // reset
  input wire logic [2:0]             i_op_mode,             // mode
  input wire logic                   i_psel,                // apb
  input wire logic                   i_penable,             // apb
  input wire logic                   i_pwrite,              // apb
  input wire pefpc_pkg::pefpc_func_s i_func,                // alt values
  input wire logic [7:0]             i_ctrl_port_direction, // gpio dir
  input wire logic [31:0]            o_prdata,              // apb
  input wire logic                   o_pready,              // apb
  input wire logic                   o_pslverr,             // apb
  input wire logic [7:0]             o_pe_out,              // pads
  input wire logic [7:0]             o_pe_oe,               // pads
  input wire logic [7:0]             o_pe_pullup,           // pads
  input wire logic [7:0]             o_high_bus_pullup,     // bus port
  input wire logic [7:0]             o_low_bus_pullup,      // bus port
  input wire logic                   o_ctrl_port_low_drive  // drive
);
  // ---
  // checks
  // ---
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_refused;
    o_pready && o_pslverr && o_prdata == 32'h0000_0000;
  endsequence
  a_low_pins_input: assert property (
    o_pe_oe[1:0] == 2'h0) else $error("interrupt pins driven");
  a_pin1_pullup_on: assert property (
    $past(i_rst_n) |-> o_pe_pullup[1]) else $error("pin 1 pullup missing");
  a_mid_pins_nopull: assert property (
    o_pe_pullup[6:4] == 3'h0) else $error("pullup on pins 6 to 4");
  a_single_gpio_pins: assert property (
    $past(i_rst_n) && $past(i_op_mode) < 3'h2 |-> {o_pe_oe[6:5], o_pe_oe[3:2]} ==
      {$past(i_ctrl_port_direction[6:5]), $past(i_ctrl_port_direction[3:2])}) else $error("alt pin in single-chip");
  a_exp_bus_clock: assert property (
    $past(i_rst_n) && $past(i_op_mode) inside {[3'h2:3'h5]} |->
      o_pe_oe[4] && o_pe_out[4] == $past(i_func.bus_clk)) else $error("bus clock missing");
  a_bus_pullup_off: assert property (
    $past(i_op_mode) >= 3'h2 |-> o_high_bus_pullup == 8'h00 && o_low_bus_pullup == 8'h00)
    else $error("bus port pullup while bus in use");
  a_periph_refused: assert property (
    s_setup ##0 i_op_mode >= 3'h6 |=> s_refused) else $error("peripheral access not refused");
  a_drive_held: assert property (
    $past(i_rst_n) && !($past(i_psel) && $past(i_pwrite)) && !($past(i_psel, 2) && $past(i_pwrite, 2))
      |-> $stable(o_ctrl_port_low_drive)) else $error("drive changed without a write");
endmodule

bind pefpc_top pefpc_asserts pefpc_asserts_inst (
  .i_clk_sys, .i_rst_n, .i_op_mode, .i_psel, .i_penable, .i_pwrite, .i_func, .i_ctrl_port_direction,
  .o_prdata, .o_pready, .o_pslverr, .o_pe_out, .o_pe_oe, .o_pe_pullup, .o_high_bus_pullup,
  .o_low_bus_pullup, .o_ctrl_port_low_drive
);

/* testbench/tb_port_e_function_pad_control.sv */
`timescale 1ns/1ps
module tb_port_e_function_pad_control;
  // ---
  // signals
  // ---
  localparam logic [11:0] A_FSEL = {2'h0, pefpc_pkg::IDX_FSEL, 2'h0};
  localparam logic [11:0] A_PULL = {2'h0, pefpc_pkg::IDX_PULLUP, 2'h0};
  localparam logic [11:0] A_DRV  = {2'h0, pefpc_pkg::IDX_DRIVE, 2'h0};
  logic                   i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite, tag, err;
  logic [2:0]             i_op_mode;
  logic [3:0]             i_pstrb;
  logic [11:0]            i_paddr;
  logic [31:0]            i_pwdata, o_prdata, rd;
  logic                   o_pready, o_pslverr, o_ctrl_port_low_drive;
  logic                   o_high_bus_port_low_drive, o_low_bus_port_low_drive;
  logic [7:0]             i_ctrl_port_direction, i_ctrl_port_data, i_high_bus_dir, i_low_bus_dir, i_pe_in;
  logic [7:0]             o_pe_out, o_pe_oe, o_pe_pullup, o_ctrl_port_in, o_high_bus_pullup, o_low_bus_pullup;
  pefpc_pkg::pefpc_func_s i_func;
  int                     fail_count, num_checks, cyc;
  logic [7:0]             rst_tbl [6] = '{8'h90, 8'h80, 8'h80, 8'h80, 8'hAC, 8'hAC};

  pefpc_top #(.ADDR_W(12)) pefpc_top_inst (
    .i_clk_sys, .i_rst_n, .i_op_mode, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
    .o_prdata, .o_pready, .o_pslverr, .i_func, .i_ctrl_port_direction, .i_ctrl_port_data,
    .i_high_bus_dir, .i_low_bus_dir, .i_pe_in, .o_pe_out, .o_pe_oe, .o_pe_pullup, .o_ctrl_port_in,
    .o_high_bus_pullup, .o_low_bus_pullup, .o_ctrl_port_low_drive, .o_high_bus_port_low_drive,
    .o_low_bus_port_low_drive);
  pefpc_pad_model pefpc_pad_model_inst (
    .i_clk_sys, .i_out(o_pe_out), .i_oe(o_pe_oe), .i_pull(o_pe_pullup), .i_tag(tag), .o_level(i_pe_in));

  // ---
  // tasks
  // ---
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk_sys);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    do @(posedge i_clk_sys); while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'h1, a, d, s);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'h0, a, 32'h0, 4'hF);
    check(rd, exp);
    check({31'h0, err}, {31'h0, e});
  endtask
  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic setdir(input logic [7:0] d);
    @(posedge i_clk_sys);
    i_ctrl_port_direction <= d;
    settle;
  endtask
  task automatic reset_to(input logic [2:0] m);
    @(posedge i_clk_sys);
    i_rst_n <= 1'h0;
    i_op_mode <= m;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
  endtask
  task automatic oe_chk(input logic [7:0] mask, input logic [7:0] exp);
    check({24'h0, o_pe_oe & mask}, {24'h0, exp});
  endtask
  task automatic out_chk(input logic [7:0] mask, input logic [7:0] exp);
    check({24'h0, o_pe_out & mask}, {24'h0, exp});
  endtask

  // ---
  // clock, timeout, sequence
  // ---
  initial begin
    i_clk_sys = 1'h0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // bus clock toggles so pin 4 cannot pass on a stuck level
  always @(posedge i_clk_sys) begin
    i_func.bus_clk <= ~i_func.bus_clk;
    cyc++;
    if (cyc > 8000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, tag, i_op_mode, i_pstrb, i_paddr, i_pwdata} = '0;
    {i_ctrl_port_direction, i_high_bus_dir, i_low_bus_dir} = '0;
    i_ctrl_port_data = 8'hFF;
    i_func = 7'h5A;
    for (int m = 0; m < 6; m++) begin
      reset_to(3'(m));
      rdchk(A_FSEL, {24'h0, rst_tbl[m]}, 1'h0);
      rdchk(A_PULL, 32'h10, 1'h0);
      rdchk(A_DRV, 32'h0, 1'h0);
      settle;
      oe_chk(8'hFC, m > 3 ? 8'h7C : (m != 0 ? 8'h10 : 8'h00));
      if (m > 3) out_chk(8'h6C, 8'h28);
    end
    reset_to(3'h6);
    rdchk(A_FSEL, 32'h0, 1'h1);
    wrt(A_FSEL, 32'hFC, 4'h1);
    check({31'h0, err}, 32'h1);
    rdchk(A_PULL, 32'h0, 1'h1);
    rdchk(A_DRV, 32'h0, 1'h1);
    @(posedge i_clk_sys);
    i_op_mode <= 3'h0;
    rdchk(A_FSEL, 32'h0, 1'h0);
    reset_to(3'h2);
    setdir(8'h04);
    wrt(A_FSEL, 32'h1C, 4'h1);
    rdchk(A_FSEL, 32'h0C, 1'h0);
    wrt(A_FSEL, 32'h80, 4'h1);
    rdchk(A_FSEL, 32'h0C, 1'h0);
    settle;
    oe_chk(8'hFC, 8'h94);
    out_chk(8'h84, 8'h80);
    reset_to(3'h3);
    wrt(A_FSEL, 32'h08, 4'h1);
    settle;
    oe_chk(8'h08, 8'h08);
    reset_to(3'h5);
    setdir(8'h00);
    wrt(A_FSEL, 32'h0, 4'h1);
    rdchk(A_FSEL, 32'hAC, 1'h0);
    wrt(A_FSEL, 32'hE0, 4'h1);
    settle;
    oe_chk(8'h60, 8'h60);
    out_chk(8'h60, 8'h20);
    wrt(A_FSEL, 32'h40, 4'h1);
    settle;
    oe_chk(8'h6C, 8'h40);
    out_chk(8'h40, 8'h40);
    reset_to(3'h0);
    wrt(A_FSEL, 32'h74, 4'h1);
    rdchk(A_FSEL, 32'h74, 1'h0);
    settle;
    oe_chk(8'hF4, 8'h80);
    wrt(A_FSEL, 32'h0, 4'h1);
    rdchk(A_FSEL, 32'h74, 1'h0);
    wrt(A_DRV, 32'h13, 4'h1);
    rdchk(A_DRV, 32'h13, 1'h0);
    settle;
    check({29'h0, o_ctrl_port_low_drive, o_low_bus_port_low_drive, o_high_bus_port_low_drive}, 32'h7);
    wrt(A_DRV, 32'h0, 4'h1);
    rdchk(A_DRV, 32'h13, 1'h0);
    rdchk(12'h03C, 32'h0, 1'h1);
    reset_to(3'h0);
    setdir(8'hFF);
    oe_chk(8'h03, 8'h00);
    check({24'h0, o_pe_pullup}, 32'h03);
    setdir(8'h00);
    check({24'h0, o_pe_pullup}, 32'h8F);
    wrt(A_PULL, 32'h03, 4'h1);
    rdchk(A_PULL, 32'h03, 1'h0);
    settle;
    check({24'h0, o_pe_pullup}, 32'h02);
    check({16'h0, o_high_bus_pullup, o_low_bus_pullup}, 32'hFFFF);
    @(posedge i_clk_sys);
    i_low_bus_dir <= 8'h0F;
    tag <= 1'h1;
    settle;
    check({24'h0, o_low_bus_pullup}, 32'hF0);
    check({31'h0, o_ctrl_port_in[3]}, 32'h0);
    @(posedge i_clk_sys);
    #1;
    check({31'h0, o_ctrl_port_in[3]}, 32'h0);
    reset_to(3'h1);
    settle;
    oe_chk(8'h10, 8'h10);
    wrt(A_FSEL, 32'h90, 4'h1);
    rdchk(A_FSEL, 32'h90, 1'h0);
    settle;
    oe_chk(8'h10, 8'h00);
    wrt(A_FSEL, 32'h0980, 4'h3);
    rdchk(A_FSEL, 32'h0980, 1'h0);
    settle;
    oe_chk(8'h10, 8'h10);
    wrt(A_FSEL, 32'h0100, 4'h2);
    settle;
    oe_chk(8'h10, 8'h00);
    wrt(A_DRV, 32'h13, 4'h1);
    rdchk(A_DRV, 32'h0, 1'h0);
    wrt(A_DRV, 32'h13, 4'h1);
    rdchk(A_DRV, 32'h13, 1'h0);
    end_of_test;
  end
endmodule
